// ==== rtl/pin_mux_pkg.sv ====
// Purpose: Constants shared by the pin multiplexer and boot port select.
// Assumes: Sixteen multiplexed pins, indexed by their rapid I/O bit.
// Notes:   Select codes pick the first, second or third listed function.
package pin_mux_pkg;
  localparam int          PIN_COUNT       = 16;
  // Per-pin function select codes
  localparam logic [1:0]  SEL_DEFAULT     = 2'h0;
  localparam logic [1:0]  SEL_SECOND      = 2'h1;
  localparam logic [1:0]  SEL_THIRD       = 2'h2;
  localparam logic [1:0]  SEL_OFF         = 2'h3;
  localparam logic [31:0] PIN_SEL_RESET   = 32'h0000_0000;
  // Master I2C routing
  localparam logic [1:0]  ROUTE_MOVED     = 2'h1;
  localparam logic [1:0]  ENB_BOTH        = 2'h3;
  localparam int          CLK_DEF_BIT     = 14;
  localparam int          DATA_DEF_BIT    = 15;
  localparam int          CLK_ALT_BIT     = 2;
  localparam int          DATA_ALT_BIT    = 3;
  localparam int          STRAP_BIT       = 8;
  // Which slot of each pin is the rapid I/O bit, and which pins have slot 3
  localparam logic [15:0] RAPID_IN_FIRST  = 16'h01FC;
  localparam logic [15:0] RAPID_IN_SECOND = 16'hFE03;
  localparam logic [15:0] HAS_THIRD       = 16'h00EF;
  // Pins forced to their third function when the slave port is SPI
  localparam logic [15:0] SPI_PINS        = 16'h000F;
  // ROM command interpreter codes
  localparam logic [2:0]  CMD_PROGRAM     = 3'h1;
  localparam logic [2:0]  CMD_ERASE       = 3'h2;
  localparam logic [2:0]  CMD_PROTECT     = 3'h3;
  localparam logic [2:0]  CMD_RESET       = 3'h4;
  localparam logic [2:0]  CMD_INFO        = 3'h5;
  localparam logic [1:0]  ERR_NONE        = 2'h0;
  localparam logic [1:0]  ERR_BAD_CMD     = 2'h1;
  localparam logic [1:0]  ERR_PROTECTED   = 2'h2;
endpackage

// ==== rtl/pin_mux_boot_port_select.sv ====
// Purpose: Pin function multiplexer with boot-time slave port selection.
// Assumes: All inputs synchronous to ref_clk_i; pads resolved outside.
// Notes:   Every output but the tied-low reset_pin_n_out_o is registered, so pads follow inputs one cycle late.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Reset leaves every pin undriven; pin_sel_i applies after
// - Firmware select fields choose each pin function except bit14, bit15, routed bit2/bit3 and SPI-strapped bits 0-3
// - Drive strength and pullup set separately
// - Clock route 01 moves clock to bit2
// - Data route 01 moves data to bit3
// - Reset pin input only, optionally open drain
// - Strap low at startup selects SPI slave
// - Boot to flash only when field set
// - Slave port works while CPU sleeps
// - Host access may wake the CPU
// - Sixteen pins carry rapid I/O or alternates
// - Bit3 pin: data second, select third
// - ROM commands program, erase, protect, reset, info
// - I2C default pins rapid only when enabled
module pin_mux_boot_port_select (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [31:0] pin_sel_i,
  input  wire logic [1:0]  clock_route_field_i,
  input  wire logic [1:0]  data_route_field_i,
  input  wire logic [15:0] rapid_io_enable_bits_i,
  input  wire logic [15:0] drive_strength_i,
  input  wire logic [15:0] pullup_en_i,
  input  wire logic [15:0] pad_in_i,
  input  wire logic [15:0] rapid_io_port_out_i,
  input  wire logic [15:0] rapid_io_port_oe_i,
  input  wire logic [15:0] first_fn_out_i,
  input  wire logic [15:0] first_fn_oe_i,
  input  wire logic [15:0] second_fn_out_i,
  input  wire logic [15:0] second_fn_oe_i,
  input  wire logic [15:0] third_fn_out_i,
  input  wire logic [15:0] third_fn_oe_i,
  input  wire logic        master_i2c_clock_out_i,
  input  wire logic        master_i2c_clock_oe_i,
  input  wire logic        master_i2c_data_out_i,
  input  wire logic        master_i2c_data_oe_i,
  input  wire logic        reset_pin_n_in_i,
  input  wire logic        reset_drive_en_i,
  input  wire logic        reset_request_i,
  input  wire logic        boot_done_i,
  input  wire logic        boot_from_flash_i,
  input  wire logic        host_access_i,
  input  wire logic        wake_on_host_en_i,
  input  wire logic        rom_cmd_valid_i,
  input  wire logic [2:0]  rom_cmd_i,
  output logic [15:0]      pad_out_o,
  output logic [15:0]      pad_oe_o,
  output logic [15:0]      pad_drive_o,
  output logic [15:0]      pad_pullup_o,
  output logic [15:0]      pin_in_o,
  output logic             master_i2c_clock_in_o,
  output logic             master_i2c_data_in_o,
  output logic             reset_pin_n_out_o,
  output logic             reset_pin_n_oe_o,
  output logic             external_reset_o,
  output logic             slave_port_spi_o,
  output logic             slave_port_ready_o,
  output logic             run_user_code_o,
  output logic             cpu_wake_o,
  output logic             flash_program_o,
  output logic             flash_erase_o,
  output logic             flash_protect_o,
  output logic             device_reset_o,
  output logic             info_read_o,
  output logic [1:0]       error_code_o
);
  logic [15:0] pad_out_reg, pad_out_next, pad_oe_reg, pad_oe_next;
  logic [15:0] drive_reg, pullup_reg, pin_in_reg;
  logic [1:0]  eff_sel [16];
  logic        clk_moved, data_moved, rapid_top;
  logic        mclk_in_reg, mclk_in_next, mdata_in_reg, mdata_in_next;
  logic        rst_oe_reg, rst_oe_next, ext_rst_reg;
  logic        strap_done_reg, strap_done_next, spi_reg, spi_next;
  logic        run_user_reg, run_user_next, wake_reg, wake_next;
  logic [4:0]  cmd_reg, cmd_next;
  logic        protect_reg, protect_next;
  logic [1:0]  err_reg, err_next;

  // Master I2C routing decisions
  assign clk_moved  = (clock_route_field_i == pin_mux_pkg::ROUTE_MOVED);
  assign data_moved = (data_route_field_i == pin_mux_pkg::ROUTE_MOVED);
  assign rapid_top  = clk_moved && data_moved &&
    (rapid_io_enable_bits_i[pin_mux_pkg::DATA_DEF_BIT -: 2] ==
     pin_mux_pkg::ENB_BOTH);

  // Per-pin effective select and single-source output mux
  for (genvar b = 0; b < pin_mux_pkg::PIN_COUNT; b++) begin : g_pin
    always_comb begin
      eff_sel[b] = pin_sel_i[2*b +: 2];
      if (b == pin_mux_pkg::CLK_DEF_BIT) begin
        eff_sel[b] = !clk_moved ? pin_mux_pkg::SEL_DEFAULT :
          (rapid_top ? pin_mux_pkg::SEL_SECOND : pin_mux_pkg::SEL_OFF);
      end else if (b == pin_mux_pkg::DATA_DEF_BIT) begin
        eff_sel[b] = !data_moved ? pin_mux_pkg::SEL_DEFAULT :
          (rapid_top ? pin_mux_pkg::SEL_SECOND : pin_mux_pkg::SEL_OFF);
      end else if (b == pin_mux_pkg::CLK_ALT_BIT && clk_moved) begin
        eff_sel[b] = pin_mux_pkg::SEL_SECOND;
      end else if (b == pin_mux_pkg::DATA_ALT_BIT && data_moved) begin
        eff_sel[b] = pin_mux_pkg::SEL_SECOND;
      end else if (pin_mux_pkg::SPI_PINS[b] && spi_reg) begin
        eff_sel[b] = pin_mux_pkg::SEL_THIRD;
      end
      if (eff_sel[b] == pin_mux_pkg::SEL_THIRD && !pin_mux_pkg::HAS_THIRD[b])
        eff_sel[b] = pin_mux_pkg::SEL_OFF;
    end
    // Only the chosen source reaches the driver
    always_comb begin
      case (eff_sel[b])
        pin_mux_pkg::SEL_DEFAULT: begin
          if (pin_mux_pkg::RAPID_IN_FIRST[b]) begin
            pad_out_next[b] = rapid_io_port_out_i[b];
            pad_oe_next[b]  = rapid_io_port_oe_i[b];
          end else if (b == pin_mux_pkg::CLK_DEF_BIT) begin
            pad_out_next[b] = master_i2c_clock_out_i;
            pad_oe_next[b]  = master_i2c_clock_oe_i;
          end else if (b == pin_mux_pkg::DATA_DEF_BIT) begin
            pad_out_next[b] = master_i2c_data_out_i;
            pad_oe_next[b]  = master_i2c_data_oe_i;
          end else begin
            pad_out_next[b] = first_fn_out_i[b];
            pad_oe_next[b]  = first_fn_oe_i[b];
          end
        end
        pin_mux_pkg::SEL_SECOND: begin
          if (pin_mux_pkg::RAPID_IN_SECOND[b]) begin
            pad_out_next[b] = rapid_io_port_out_i[b];
            pad_oe_next[b]  = rapid_io_port_oe_i[b];
          end else if (b == pin_mux_pkg::CLK_ALT_BIT && clk_moved) begin
            pad_out_next[b] = master_i2c_clock_out_i;
            pad_oe_next[b]  = master_i2c_clock_oe_i;
          end else if (b == pin_mux_pkg::DATA_ALT_BIT && data_moved) begin
            pad_out_next[b] = master_i2c_data_out_i;
            pad_oe_next[b]  = master_i2c_data_oe_i;
          end else begin
            pad_out_next[b] = second_fn_out_i[b];
            pad_oe_next[b]  = second_fn_oe_i[b];
          end
        end
        pin_mux_pkg::SEL_THIRD: begin
          pad_out_next[b] = third_fn_out_i[b];
          pad_oe_next[b]  = third_fn_oe_i[b];
        end
        default: begin
          pad_out_next[b] = 1'b0;
          pad_oe_next[b]  = 1'b0;
        end
      endcase
    end
  end

  // Routed master I2C inputs, reset pin, boot, wake and ROM commands
  always_comb begin
    mclk_in_next    = clk_moved ? pad_in_i[pin_mux_pkg::CLK_ALT_BIT]
                                : pad_in_i[pin_mux_pkg::CLK_DEF_BIT];
    mdata_in_next   = data_moved ? pad_in_i[pin_mux_pkg::DATA_ALT_BIT]
                                 : pad_in_i[pin_mux_pkg::DATA_DEF_BIT];
    rst_oe_next     = reset_drive_en_i && reset_request_i;
    strap_done_next = 1'b1;
    spi_next        = spi_reg;
    if (!strap_done_reg)
      spi_next = !pad_in_i[pin_mux_pkg::STRAP_BIT];
    run_user_next   = run_user_reg;
    if (boot_done_i)
      run_user_next = boot_from_flash_i;
    wake_next       = host_access_i && wake_on_host_en_i;
    cmd_next        = 5'h00;
    protect_next    = protect_reg;
    err_next        = err_reg;
    if (rom_cmd_valid_i) begin
      err_next = pin_mux_pkg::ERR_NONE;
      case (rom_cmd_i)
        pin_mux_pkg::CMD_PROGRAM, pin_mux_pkg::CMD_ERASE: begin
          if (protect_reg)
            err_next = pin_mux_pkg::ERR_PROTECTED;
          else if (rom_cmd_i == pin_mux_pkg::CMD_PROGRAM)
            cmd_next[0] = 1'b1;
          else
            cmd_next[1] = 1'b1;
        end
        pin_mux_pkg::CMD_PROTECT: begin
          cmd_next[2]  = 1'b1;
          protect_next = 1'b1;
        end
        pin_mux_pkg::CMD_RESET: cmd_next[3] = 1'b1;
        pin_mux_pkg::CMD_INFO:  cmd_next[4] = 1'b1;
        default: err_next = pin_mux_pkg::ERR_BAD_CMD;
      endcase
    end
  end

  // State registers; reset values leave every pad undriven with its output low
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_out_reg    <= 16'h0000;
      pad_oe_reg     <= 16'h0000;
      drive_reg      <= 16'h0000;
      pullup_reg     <= 16'h0000;
      pin_in_reg     <= 16'h0000;
      mclk_in_reg    <= 1'b1;
      mdata_in_reg   <= 1'b1;
      rst_oe_reg     <= 1'b0;
      ext_rst_reg    <= 1'b0;
      strap_done_reg <= 1'b0;
      spi_reg        <= 1'b0;
      run_user_reg   <= 1'b0;
      wake_reg       <= 1'b0;
      cmd_reg        <= 5'h00;
      protect_reg    <= 1'b0;
      err_reg        <= pin_mux_pkg::ERR_NONE;
    end else begin
      pad_out_reg    <= pad_out_next;
      pad_oe_reg     <= pad_oe_next;
      drive_reg      <= drive_strength_i;
      pullup_reg     <= pullup_en_i;
      pin_in_reg     <= pad_in_i;
      mclk_in_reg    <= mclk_in_next;
      mdata_in_reg   <= mdata_in_next;
      rst_oe_reg     <= rst_oe_next;
      ext_rst_reg    <= !reset_pin_n_in_i;
      strap_done_reg <= strap_done_next;
      spi_reg        <= spi_next;
      run_user_reg   <= run_user_next;
      wake_reg       <= wake_next;
      cmd_reg        <= cmd_next;
      protect_reg    <= protect_next;
      err_reg        <= err_next;
    end
  end

  // Outputs straight from flops, reset pin level tied low; slave port ready does not wait on CPU
  assign pad_out_o             = pad_out_reg;
  assign pad_oe_o              = pad_oe_reg;
  assign pad_drive_o           = drive_reg;
  assign pad_pullup_o          = pullup_reg;
  assign pin_in_o              = pin_in_reg;
  assign master_i2c_clock_in_o = mclk_in_reg;
  assign master_i2c_data_in_o  = mdata_in_reg;
  assign reset_pin_n_out_o     = 1'b0; // Open drain: only ever pulls low
  assign reset_pin_n_oe_o      = rst_oe_reg;
  assign external_reset_o      = ext_rst_reg;
  assign slave_port_spi_o      = spi_reg;
  assign slave_port_ready_o    = strap_done_reg;
  assign run_user_code_o       = run_user_reg;
  assign cpu_wake_o            = wake_reg;
  assign flash_program_o       = cmd_reg[0];
  assign flash_erase_o         = cmd_reg[1];
  assign flash_protect_o       = cmd_reg[2];
  assign device_reset_o        = cmd_reg[3];
  assign info_read_o           = cmd_reg[4];
  assign error_code_o          = err_reg;

  // Checks, held off until the flops have loaded once after reset
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i || !strap_done_reg);
  clock_moved_a: assert property (
    clk_moved && rapid_top == 1'b0 |=> pad_oe_o[14] == 1'b0 &&
      pad_out_o[2] == $past(master_i2c_clock_out_i))
    else $error("master clock not moved to bit 2 pin");
  data_moved_a: assert property (
    data_moved |=> pad_oe_o[3] == $past(master_i2c_data_oe_i))
    else $error("master data not moved to bit 3 pin");
  top_rapid_a: assert property (
    rapid_top |=> pad_out_o[15:14] == $past(rapid_io_port_out_i[15:14]))
    else $error("top pins not rapid I/O when enabled");
  clock_default_a: assert property (
    !clk_moved |=> pad_out_o[14] == $past(master_i2c_clock_out_i))
    else $error("master clock left its default pin");
  strap_hold_a: assert property (
    strap_done_reg |=> $stable(slave_port_spi_o))
    else $error("slave port mode changed after startup");
  reset_drive_a: assert property (
    !reset_drive_en_i |=> !reset_pin_n_oe_o)
    else $error("reset pin driven while input only");
  boot_flash_a: assert property (
    boot_done_i && !boot_from_flash_i |=> !run_user_code_o)
    else $error("left ROM without boot from flash");
  host_wake_a: assert property (
    host_access_i && wake_on_host_en_i |=> cpu_wake_o)
    else $error("host access did not wake the CPU");
  pad_style_a: assert property (
    ##1 pad_pullup_o == $past(pullup_en_i) &&
      pad_drive_o == $past(drive_strength_i))
    else $error("pad style not taken from port control");
  protect_block_a: assert property (
    protect_reg && rom_cmd_valid_i && rom_cmd_i == pin_mux_pkg::CMD_ERASE
      |=> !flash_erase_o && error_code_o == pin_mux_pkg::ERR_PROTECTED)
    else $error("erase allowed on protected flash");
  spi_pick_c: cover property (strap_done_reg && slave_port_spi_o);
  route_c:    cover property (clk_moved && data_moved && rapid_top);
  wake_c:     cover property (cpu_wake_o);
endmodule
`default_nettype wire

// ==== verification/host_port_model.sv ====
// Purpose: Host on the slave port: sends ROM commands, makes accesses.
// Assumes: Driven from the bench by task calls; one clock domain.
// Notes:   Released code lines show the inverse of the last code.
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input  wire logic  clk_i,
  output logic       rom_cmd_valid_o,
  output logic [2:0] rom_cmd_o,
  output logic       host_access_o
);
  // Idle lines at time zero
  initial begin
    rom_cmd_valid_o = 1'h0;
    rom_cmd_o       = 3'h0;
    host_access_o   = 1'h0;
  end
  // One command with its access for one cycle, then lines released
  task automatic send_cmd(input logic [2:0] code);
    @(posedge clk_i);
    rom_cmd_valid_o <= 1'h1;
    rom_cmd_o       <= code;
    host_access_o   <= 1'h1;  // Access at any time, CPU asleep or not
    @(posedge clk_i);
    rom_cmd_valid_o <= 1'h0;
    rom_cmd_o       <= ~code;
    host_access_o   <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_pin_mux_boot_port_select.sv ====
// Purpose: Self-checking bench for the pin mux and boot port select.
// Assumes: Outputs registered one cycle behind the inputs.
// Notes:   Sources are inverted between cases so stale routing shows.
`timescale 1ns/1ps
`default_nettype none
module tb_pin_mux_boot_port_select;
  logic        ref_clk_i = 1'h0;
  logic        rst_n_i = 1'h0;
  logic [31:0] pin_sel;
  logic [1:0]  crf, drf, err;
  logic [15:0] enb, pad_in, drv, pul, so[4], soe[4];
  logic [15:0] pad_out, pad_oe, pad_drive, pad_pull, pin_in;
  logic [3:0]  m;
  logic        rst_in, rst_en, rst_req, boot_done, boot_flash, wake_en;
  logic        mclk_in, mdat_in, rp_out, rp_oe, ext_rst, spi, ready;
  logic        run, wake, fp, fe, fpr, dr, ir, cv, ha, exp_spi;
  logic [2:0]  cc;
  logic [5:0]  rt [5] = '{6'h10, 6'h04, 6'h17, 6'h14, 6'h03};
  logic [2:0]  seq [8] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h3, 3'h1, 3'h2, 3'h7};
  logic [4:0]  exp_p [8] = '{5'h01, 5'h02, 5'h08, 5'h10, 5'h04, 5'h0, 5'h0,
                             5'h0};
  logic [1:0]  exp_e [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h1};
  int          bad_count = 0;
  int          checked = 0;
  // Clock at 250 MHz
  always #2 ref_clk_i = ~ref_clk_i;
  pin_mux_boot_port_select u_pin_mux_boot_port_select (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pin_sel_i(pin_sel),
    .clock_route_field_i(crf), .data_route_field_i(drf),
    .rapid_io_enable_bits_i(enb), .drive_strength_i(drv),
    .pullup_en_i(pul), .pad_in_i(pad_in),
    .rapid_io_port_out_i(so[0]), .rapid_io_port_oe_i(soe[0]),
    .first_fn_out_i(so[1]), .first_fn_oe_i(soe[1]),
    .second_fn_out_i(so[2]), .second_fn_oe_i(soe[2]),
    .third_fn_out_i(so[3]), .third_fn_oe_i(soe[3]),
    .master_i2c_clock_out_i(m[0]), .master_i2c_clock_oe_i(m[1]),
    .master_i2c_data_out_i(m[2]), .master_i2c_data_oe_i(m[3]),
    .reset_pin_n_in_i(rst_in), .reset_drive_en_i(rst_en),
    .reset_request_i(rst_req), .boot_done_i(boot_done),
    .boot_from_flash_i(boot_flash), .host_access_i(ha),
    .wake_on_host_en_i(wake_en), .rom_cmd_valid_i(cv), .rom_cmd_i(cc),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pad_drive_o(pad_drive),
    .pad_pullup_o(pad_pull), .pin_in_o(pin_in),
    .master_i2c_clock_in_o(mclk_in), .master_i2c_data_in_o(mdat_in),
    .reset_pin_n_out_o(rp_out), .reset_pin_n_oe_o(rp_oe),
    .external_reset_o(ext_rst), .slave_port_spi_o(spi),
    .slave_port_ready_o(ready), .run_user_code_o(run), .cpu_wake_o(wake),
    .flash_program_o(fp), .flash_erase_o(fe), .flash_protect_o(fpr),
    .device_reset_o(dr), .info_read_o(ir), .error_code_o(err));
  host_port_model u_host_port_model (
    .clk_i(ref_clk_i), .rom_cmd_valid_o(cv), .rom_cmd_o(cc),
    .host_access_o(ha));
  // Compare one value and count it
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Expected pad drive: 0..3 source slot, 4 off, 5/6 master clock/data
  task automatic check_pads();
    logic [15:0] o, e;
    int          s;
    logic [1:0]  sel;
    for (int b = 0; b < 16; b++) begin
      sel = pin_sel[2*b+:2];
      if (sel == 2'h0) s = pin_mux_pkg::RAPID_IN_FIRST[b] ? 0 : 1;
      else if (sel == 2'h1) s = pin_mux_pkg::RAPID_IN_SECOND[b] ? 0 : 2;
      else if (sel == 2'h2) s = pin_mux_pkg::HAS_THIRD[b] ? 3 : 4;
      else s = 4;
      if (exp_spi && pin_mux_pkg::SPI_PINS[b]) s = 3;
      if (b == 14)
        s = crf != 2'h1 ? 5 : (drf == 2'h1 && enb[15:14] == 2'h3) ? 0 : 4;
      if (b == 15)
        s = drf != 2'h1 ? 6 : (crf == 2'h1 && enb[15:14] == 2'h3) ? 0 : 4;
      if (b == 2 && crf == 2'h1) s = 5;
      if (b == 3 && drf == 2'h1) s = 6;
      o[b] = s < 4 ? so[s][b] : s == 5 ? m[0] : s == 6 ? m[2] : 1'h0;
      e[b] = s < 4 ? soe[s][b] : s == 5 ? m[1] : s == 6 ? m[3] : 1'h0;
    end
    chk(pad_oe, e);
    chk(pad_out & e, o & e);
  endtask
  // Let the registered outputs follow
  task automatic settle();
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask
  // Invert every source so a stuck routing shows
  task automatic flip();
    for (int i = 0; i < 4; i++) begin
      so[i]  <= ~so[i];
      soe[i] <= ~soe[i];
    end
    m   <= ~m;
    drv <= ~drv;
    pul <= ~pul;
  endtask
  // Reset for 20 cycles with the strap level given
  task automatic do_reset(input logic strap);
    @(posedge ref_clk_i);
    rst_n_i    <= 1'h0;
    pad_in[8]  <= strap;  // Host side sets the port strap
    repeat (20) @(posedge ref_clk_i);
    rst_n_i    <= 1'h1;
    exp_spi    = ~strap;
    @(posedge ref_clk_i);
    #1;
  endtask
  // Counts and verdict
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (4000) @(posedge ref_clk_i);
    bad_count++;
    test_done();
  end
  // Main sequence
  initial begin
    pin_sel    = 32'h0;
    crf        = 2'h0;
    drf        = 2'h0;
    enb        = 16'h0;
    pad_in     = 16'h010C;
    so         = '{16'hA5A5, 16'h3C3C, 16'h0FF0, 16'hC3C3};
    soe        = '{16'hFFFF, 16'h00FF, 16'hF0F0, 16'h5A5A};
    m          = 4'hD;
    drv        = 16'h1234;
    pul        = 16'h00F0;
    rst_in     = 1'h1;
    rst_en     = 1'h0;
    rst_req    = 1'h0;
    boot_done  = 1'h0;
    boot_flash = 1'h0;
    wake_en    = 1'h0;
    exp_spi    = 1'h0;
    do_reset(1'h1);
    chk(spi, 1'h0);
    chk(ready, 1'h1);
    check_pads();
    chk(pin_in, pad_in);
    for (int c = 0; c < 4; c++) begin
      @(posedge ref_clk_i);
      pin_sel <= {16{c[1:0]}};
      flip();
      settle();
      check_pads();
      chk(pad_drive, drv);
      chk(pad_pull, pul);
    end
    for (int r = 0; r < 5; r++) begin
      @(posedge ref_clk_i);
      pin_sel <= 32'h0;
      {crf, drf, enb[15:14]} <= rt[r];
      settle();
      check_pads();
      chk(mclk_in, crf == 2'h1 ? pad_in[2] : pad_in[14]);
      chk(mdat_in, drf == 2'h1 ? pad_in[3] : pad_in[15]);
    end
    @(posedge ref_clk_i);
    rst_req <= 1'h1;
    settle();
    chk(rp_oe, 1'h0);
    @(posedge ref_clk_i);
    rst_en <= 1'h1;
    rst_in <= 1'h0;
    settle();
    chk({rp_oe, rp_out, ext_rst}, 3'h5);
    @(posedge ref_clk_i);
    rst_en <= 1'h0;
    rst_in <= 1'h1;
    settle();
    chk({rp_oe, ext_rst}, 2'h0);
    for (int f = 0; f < 2; f++) begin
      @(posedge ref_clk_i);
      boot_flash <= !f[0];
      boot_done  <= 1'h1;
      @(posedge ref_clk_i);
      boot_done  <= 1'h0;
      boot_flash <= f[0];
      #1;
      chk(run, !f[0]);
      settle();
      chk(run, !f[0]);
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk_i);
      wake_en <= i[0];
      u_host_port_model.send_cmd(seq[i]);
      #1;
      chk({ir, dr, fpr, fe, fp}, exp_p[i]);
      chk(err, exp_e[i]);
      chk(wake, i[0]);
      @(posedge ref_clk_i);
      #1;
      chk({ir, dr, fpr, fe, fp, wake}, 6'h0);
    end
    do_reset(1'h0);
    chk(spi, 1'h1);
    @(posedge ref_clk_i);
    pad_in[8] <= 1'h1;
    settle();
    chk(spi, 1'h1);
    check_pads();
    test_done();
  end
endmodule
`default_nettype wire
